/* File: hw/sro_cfg.svh */
// constants for the sensor readout two-wire slave
`ifndef SRO_CFG_SVH
`define SRO_CFG_SVH

// selectable factory slave addresses
`define SRO_ADDR_VAR0 7'h28
`define SRO_ADDR_VAR1 7'h36
`define SRO_ADDR_VAR2 7'h46

// direction bit values in the header byte
`define SRO_DIR_WRITE 1'h0
`define SRO_DIR_READ 1'h1

// status field codes
`define SRO_STAT_FRESH 2'h0
`define SRO_STAT_STALE 2'h2

// packet field slices
`define SRO_BRIDGE_HI 13:8
`define SRO_BRIDGE_LO 7:0
`define SRO_TEMP_HI 10:3
`define SRO_TEMP_LO 2:0
`define SRO_PAD_BITS 5'h00
`define SRO_IDLE_BYTE 8'hFF

// bit and byte counting
`define SRO_BIT_FIRST 3'h0
`define SRO_BIT_LAST 3'h7
`define SRO_ACK_WAIT 3'h0
`define SRO_ACK_HELD 3'h1
`define SRO_BYTE_FIRST 3'h0
`define SRO_BYTE_LAST 3'h3

// clock and stretch timing
`define SRO_CLK_NS 50
`define SRO_STRETCH_NS 1000
`define SRO_STRETCH_CYC ((`SRO_STRETCH_NS + `SRO_CLK_NS - 1) / `SRO_CLK_NS)
`define SRO_CNT_ZERO 5'h00

// measurement buffer
`define SRO_FIFO_DEPTH 32

`endif

/* File: hw/sro_fifo.sv */
// measurement buffer with valid and ready on both sides
module sro_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    // fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;

    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge clk) begin
        if (clk_en && push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // ready is registered so the source sees a flop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'h1;
        end else if (clk_en) begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
            count <= next_count;
            in_ready <= (next_count != FULL);
        end
    end

endmodule

/* File: hw/sro_i2c_slave.sv */
// two-wire slave that serves buffered pressure and temperature packets
//
// Functional notes
// - header carries a seven-bit slave address, sent first by master, matched here
// - one fixed address chosen from three variants by parameter
// - ready pin rises on new measurement, falls at next bus start
// - data and clock lines only pulled low or released
// - bus counts as busy from a start condition
// - bus counts as free after a stop condition
// - receiver pulls data low during the ninth clock to acknowledge
// - data released high in the ninth clock means not-acknowledge
// - on not-acknowledge while sending, stop sending and go idle
// - clock held low after a read header acknowledge while the packet is prepared; a write header gets no stretch
// - bytes shift most significant bit first, each followed by acknowledge
// - direction one turns the bus so the device transmits
// - read sends two bridge bytes with status on top, then temperature
// - status reads 00 when fresh, 10 when already fetched
`include "sro_cfg.svh"

module sro_i2c_slave #(
    parameter logic [6:0] SLAVE_ADDR = `SRO_ADDR_VAR0
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    // bus clock pin
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    // bus data pin
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // data ready pin
    output logic ready_pin,
    // measurement input
    input wire logic meas_valid,
    input wire logic [13:0] meas_bridge,
    input wire logic [10:0] meas_temp,
    output logic meas_ready,
    // bus status
    output logic bus_busy,
    output logic rx_strobe,
    output logic [7:0] rx_data,
    output logic tx_abort
);

    sro_pkg::sro_state_t state;
    sro_pkg::sro_state_t next_state;

    logic scl_s;
    logic sda_s;
    logic scl_q;
    logic sda_q;
    logic [2:0] bit_cnt;
    logic [2:0] next_bit_cnt;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [2:0] byte_idx;
    logic [2:0] next_byte_idx;
    logic [4:0] stretch_cnt;
    logic [4:0] next_stretch_cnt;
    logic next_sda_oe;
    logic next_scl_oe;
    logic next_rx_strobe;
    logic [7:0] next_rx_data;
    logic next_tx_abort;
    logic load_packet;
    sro_pkg::sro_meas_t cur_meas;
    logic fresh;
    logic [1:0] pkt_status;
    sro_pkg::sro_meas_t fifo_data;
    logic fifo_valid;

    // pin synchronisers; bus-clock edges come from the synchronised copy
    sro_sync u_sync_scl (
        .clk(clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .async_in(scl_in),
        .sync_out(scl_s)
    );

    sro_sync u_sync_sda (
        .clk(clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .async_in(sda_in),
        .sync_out(sda_s)
    );

    // measurements wait here until the bus is idle
    wire drain = ~bus_busy;

    sro_fifo #(
        .WIDTH($bits(sro_pkg::sro_meas_t)),
        .DEPTH(`SRO_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .in_valid(meas_valid),
        .in_data({meas_bridge, meas_temp}),
        .in_ready(meas_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(drain)
    );

    // edge and condition detection on the synchronised lines
    wire scl_rise = scl_s & ~scl_q;
    wire scl_fall = ~scl_s & scl_q;
    wire start_det = scl_s & scl_q & sda_q & ~sda_s;
    wire stop_det = scl_s & scl_q & ~sda_q & sda_s;
    wire pop = fifo_valid & drain;

    wire [7:0] byte_in = {shreg[6:0], sda_s};
    wire addr_match = (shreg[7:1] == SLAVE_ADDR);
    wire dir_read = (shreg[0] == `SRO_DIR_READ);
    wire last_bit = (bit_cnt == `SRO_BIT_LAST);
    wire stretch_done = (stretch_cnt == 5'(`SRO_STRETCH_CYC - 1));
    wire master_nack = sda_s;

    // packet bytes: status over bridge high, bridge low, temperature high, temperature low padded
    wire [7:0] pkt_b0 = {pkt_status, cur_meas.bridge[`SRO_BRIDGE_HI]};
    wire [7:0] pkt_b1 = cur_meas.bridge[`SRO_BRIDGE_LO];
    wire [7:0] pkt_b2 = cur_meas.temp[`SRO_TEMP_HI];
    wire [7:0] pkt_b3 = {cur_meas.temp[`SRO_TEMP_LO], `SRO_PAD_BITS};
    wire [1:0] load_status = fresh ? `SRO_STAT_FRESH : `SRO_STAT_STALE;
    wire [7:0] first_byte = {load_status, cur_meas.bridge[`SRO_BRIDGE_HI]};
    wire [2:0] byte_succ = byte_idx + 3'h1;
    wire [7:0] succ_byte = (byte_succ == 3'h1) ? pkt_b1 :
                           (byte_succ == 3'h2) ? pkt_b2 :
                           (byte_succ == `SRO_BYTE_LAST) ? pkt_b3 : `SRO_IDLE_BYTE;
    wire past_end = (byte_idx > `SRO_BYTE_LAST);

    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_byte_idx = byte_idx;
        next_stretch_cnt = stretch_cnt;
        next_sda_oe = sda_oe;
        next_scl_oe = scl_oe;
        next_rx_strobe = 1'h0;
        next_rx_data = rx_data;
        next_tx_abort = 1'h0;
        load_packet = 1'h0;
        if (start_det) begin
            // repeated start is accepted from any state
            next_state = sro_pkg::SRO_ADDR;
            next_bit_cnt = `SRO_BIT_FIRST;
            next_sda_oe = 1'h0;
            next_scl_oe = 1'h0;
        end else if (stop_det) begin
            next_state = sro_pkg::SRO_IDLE;
            next_sda_oe = 1'h0;
            next_scl_oe = 1'h0;
        end else begin
            case (state)
                sro_pkg::SRO_ADDR: begin
                    if (scl_rise) begin
                        next_shreg = byte_in;
                        next_bit_cnt = bit_cnt + 3'h1;
                        if (last_bit) begin
                            next_state = sro_pkg::SRO_ADDR_ACK;
                        end
                    end
                end
                sro_pkg::SRO_ADDR_ACK: begin
                    if (scl_fall && bit_cnt == `SRO_ACK_WAIT) begin
                        if (addr_match) begin
                            next_sda_oe = 1'h1;
                            next_bit_cnt = `SRO_ACK_HELD;
                        end else begin
                            next_state = sro_pkg::SRO_IGNORE;
                        end
                    end else if (scl_fall) begin
                        next_sda_oe = 1'h0;
                        next_bit_cnt = `SRO_BIT_FIRST;
                        if (dir_read) begin
                            next_state = sro_pkg::SRO_STRETCH;
                            // first data bit is set up while the clock is still held low
                            next_sda_oe = ~first_byte[7];
                            next_scl_oe = 1'h1;
                            next_stretch_cnt = `SRO_CNT_ZERO;
                        end else begin
                            next_state = sro_pkg::SRO_RX;
                        end
                    end
                end
                sro_pkg::SRO_STRETCH: begin
                    next_stretch_cnt = stretch_cnt + 5'h01;
                    if (stretch_cnt == `SRO_CNT_ZERO) begin
                        load_packet = 1'h1;
                        next_shreg = first_byte;
                        next_byte_idx = `SRO_BYTE_FIRST;
                    end
                    if (stretch_done) begin
                        next_scl_oe = 1'h0;
                        next_sda_oe = ~shreg[7];
                        next_state = sro_pkg::SRO_TX;
                    end
                end
                sro_pkg::SRO_TX: begin
                    if (scl_fall) begin
                        if (last_bit) begin
                            next_sda_oe = 1'h0;
                            next_bit_cnt = `SRO_ACK_WAIT;
                            next_state = sro_pkg::SRO_TX_ACK;
                        end else begin
                            next_shreg = {shreg[6:0], 1'h0};
                            next_sda_oe = ~shreg[6];
                            next_bit_cnt = bit_cnt + 3'h1;
                        end
                    end
                end
                sro_pkg::SRO_TX_ACK: begin
                    if (scl_rise && bit_cnt == `SRO_ACK_WAIT) begin
                        if (master_nack) begin
                            next_state = sro_pkg::SRO_IDLE;
                            next_tx_abort = 1'h1;
                        end else begin
                            next_shreg = past_end ? `SRO_IDLE_BYTE : succ_byte;
                            next_byte_idx = past_end ? byte_idx : byte_succ;
                            next_bit_cnt = `SRO_ACK_HELD;
                        end
                    end else if (scl_fall && bit_cnt == `SRO_ACK_HELD) begin
                        next_sda_oe = ~shreg[7];
                        next_bit_cnt = `SRO_BIT_FIRST;
                        next_state = sro_pkg::SRO_TX;
                    end
                end
                sro_pkg::SRO_RX: begin
                    if (scl_rise) begin
                        next_shreg = byte_in;
                        next_bit_cnt = bit_cnt + 3'h1;
                        if (last_bit) begin
                            next_state = sro_pkg::SRO_RX_ACK;
                        end
                    end
                end
                sro_pkg::SRO_RX_ACK: begin
                    if (scl_fall && bit_cnt == `SRO_ACK_WAIT) begin
                        next_sda_oe = 1'h1;
                        next_bit_cnt = `SRO_ACK_HELD;
                        next_rx_strobe = 1'h1;
                        next_rx_data = shreg;
                    end else if (scl_fall) begin
                        next_sda_oe = 1'h0;
                        next_bit_cnt = `SRO_BIT_FIRST;
                        next_state = sro_pkg::SRO_RX;
                    end
                end
                default: begin
                    next_state = state;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_q <= 1'h1;
            sda_q <= 1'h1;
        end else if (clk_en) begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= sro_pkg::SRO_IDLE;
            bit_cnt <= `SRO_BIT_FIRST;
            shreg <= 8'h00;
            byte_idx <= `SRO_BYTE_FIRST;
            stretch_cnt <= `SRO_CNT_ZERO;
        end else if (clk_en) begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            byte_idx <= next_byte_idx;
            stretch_cnt <= next_stretch_cnt;
        end
    end

    // open-drain drive: the output level is always low
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sda_oe <= 1'h0;
            scl_oe <= 1'h0;
            sda_out <= 1'h0;
            scl_out <= 1'h0;
        end else if (clk_en) begin
            sda_oe <= next_sda_oe;
            scl_oe <= next_scl_oe;
            sda_out <= 1'h0;
            scl_out <= 1'h0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_strobe <= 1'h0;
            rx_data <= 8'h00;
            tx_abort <= 1'h0;
        end else if (clk_en) begin
            rx_strobe <= next_rx_strobe;
            rx_data <= next_rx_data;
            tx_abort <= next_tx_abort;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bus_busy <= 1'h0;
        end else if (clk_en) begin
            if (start_det) begin
                bus_busy <= 1'h1;
            end else if (stop_det) begin
                bus_busy <= 1'h0;
            end
        end
    end

    // a pop marks the data fresh; fetching it on a read marks it stale
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur_meas <= '0;
            fresh <= 1'h0;
            pkt_status <= `SRO_STAT_STALE;
        end else if (clk_en) begin
            if (pop) begin
                cur_meas <= fifo_data;
                fresh <= 1'h1;
            end else if (load_packet) begin
                fresh <= 1'h0;
            end
            if (load_packet) begin
                pkt_status <= load_status;
            end
        end
    end

    // set wins over the start that clears it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ready_pin <= 1'h0;
        end else if (clk_en) begin
            if (pop) begin
                ready_pin <= 1'h1;
            end else if (start_det) begin
                ready_pin <= 1'h0;
            end
        end
    end

endmodule

/* File: hw/sro_pkg.sv */
// types shared by the sensor readout slave
package sro_pkg;

    typedef enum logic [3:0] {
        SRO_IDLE     = 4'h0,
        SRO_ADDR     = 4'h1,
        SRO_ADDR_ACK = 4'h2,
        SRO_STRETCH  = 4'h3,
        SRO_TX       = 4'h4,
        SRO_TX_ACK   = 4'h5,
        SRO_RX       = 4'h6,
        SRO_RX_ACK   = 4'h7,
        SRO_IGNORE   = 4'h8
    } sro_state_t;

    typedef struct packed {
        logic [13:0] bridge;
        logic [10:0] temp;
    } sro_meas_t;

endpackage

/* File: hw/sro_sync.sv */
// two-flop synchroniser for inputs from outside the clock domain
module sro_sync (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    // signal
    input wire logic async_in,
    output logic sync_out
);

    logic stage1;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage1 <= 1'h1;
            sync_out <= 1'h1;
        end else if (clk_en) begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

/* File: test/sensor_i2c_slave_readout_test.sv */
// self-checking bench for the sensor readout two-wire slave
`include "sro_cfg.svh"
module sensor_i2c_slave_readout_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic meas_valid = 1'b0;
    logic [13:0] meas_bridge = 14'h0000;
    logic [10:0] meas_temp = 11'h000;
    logic scl_low, sda_low, scl_oe, sda_oe, ready_pin, meas_ready, bus_busy, rx_strobe, tx_abort;
    logic [7:0] rx_data;
    logic [7:0] got [4];
    int fails = 0;
    int check_count = 0;
    int aborts = 0;
    // pull-ups: a line is low while any party pulls it
    wire scl = !(scl_low || scl_oe);
    wire sda = !(sda_low || sda_oe);
    always #25 clk = !clk;
    sro_i2c_slave #(.SLAVE_ADDR(`SRO_ADDR_VAR0)) DUT (.clk(clk), .resetn(resetn), .clk_en(1'b1),
        .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
        .ready_pin(ready_pin), .meas_valid(meas_valid), .meas_bridge(meas_bridge), .meas_temp(meas_temp),
        .meas_ready(meas_ready), .bus_busy(bus_busy), .rx_strobe(rx_strobe), .rx_data(rx_data),
        .tx_abort(tx_abort));
    sro_master_model mst (.clk(clk), .scl(scl), .sda(sda), .scl_low(scl_low), .sda_low(sda_low));
    always @(posedge clk) begin
        if (tx_abort === 1'b1) begin
            aborts++;
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic wait_ready();
        int i;
        i = 0;
        while (ready_pin !== 1'b1 && i < 80) begin
            @(posedge clk);
            i++;
        end
        check(ready_pin, 1'b1, "ready");
    endtask
    task automatic read_pkt(input logic [6:0] a, input int n, output logic ack);
        @(posedge clk);
        mst.start_c();
        mst.put_byte({a, `SRO_DIR_READ}, ack);
        for (int k = 0; k < n && ack; k++) begin
            mst.get_byte(k < n - 1, got[k]);
        end
        mst.stop_c();
    endtask
    task automatic t_fresh();
        logic ack;
        check(ready_pin, 1'b0, "ready at reset");
        check(sda_oe | scl_oe | bus_busy, 1'b0, "idle at reset");
        meas_valid <= 1'b1;
        meas_bridge <= 14'h2A5C;
        meas_temp <= 11'h5A3;
        @(posedge clk);
        meas_valid <= 1'b0;
        wait_ready();
        read_pkt(`SRO_ADDR_VAR0, 4, ack);
        check(ack, 1'b1, "own header");
        check(got[0], {`SRO_STAT_FRESH, 6'h2A}, "byte0");
        check(got[1], 8'h5C, "byte1");
        check(got[2], 8'hB4, "byte2");
        check(got[3] & 8'hE0, 8'h60, "byte3");
        check(mst.held_max > 10, 1'b1, "stretch");
        check(ready_pin, 1'b0, "ready after read");
        $display("test fresh read done");
    endtask
    task automatic t_stale();
        logic ack;
        int a0;
        a0 = aborts;
        read_pkt(`SRO_ADDR_VAR0, 2, ack);
        check(got[0], {`SRO_STAT_STALE, 6'h2A}, "stale byte0");
        check(got[1], 8'h5C, "stale byte1");
        check(aborts - a0 == 1, 1'b1, "abort on nack");
        $display("test stale read done");
    endtask
    task automatic t_addr();
        logic [6:0] other [2] = '{`SRO_ADDR_VAR1, `SRO_ADDR_VAR2};
        logic ack;
        for (int k = 0; k < 2; k++) begin
            read_pkt(other[k], 1, ack);
            check(ack, 1'b0, "foreign header");
        end
        @(posedge clk);
        mst.start_c();
        mst.put_byte({`SRO_ADDR_VAR0, `SRO_DIR_WRITE}, ack);
        check(ack & bus_busy, 1'b1, "write header");
        mst.put_byte(8'hC6, ack);
        check(ack, 1'b1, "write ack");
        check(rx_data, 8'hC6, "write data");
        mst.stop_c();
        check(bus_busy, 1'b0, "bus free");
        $display("test address and write done");
    endtask
    task automatic t_fifo();
        int n;
        logic ack;
        n = 0;
        @(posedge clk);
        mst.start_c();
        repeat (8) @(posedge clk);
        meas_valid <= 1'b1;
        while (n < 40) begin
            meas_bridge <= 14'(n);
            meas_temp <= 11'(n);
            @(posedge clk);
            if (meas_ready !== 1'b1) begin
                break;
            end
            n++;
        end
        meas_valid <= 1'b0;
        check(16'(n), 16'(`SRO_FIFO_DEPTH), "words held");
        mst.put_byte({`SRO_ADDR_VAR1, `SRO_DIR_READ}, ack);
        mst.stop_c();
        // drain runs one word a cycle once the bus is free
        repeat (10) @(posedge clk);
        wait_ready();
        check(meas_ready, 1'b1, "drained");
        read_pkt(`SRO_ADDR_VAR0, 2, ack);
        check(got[0], {`SRO_STAT_FRESH, 6'h00}, "newest byte0");
        check(got[1], 8'(n - 1), "newest byte1");
        $display("test buffer fill done");
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #2ms;
        fails++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        repeat (6) @(posedge clk);
        t_fresh();
        t_stale();
        t_addr();
        t_fifo();
        give_verdict();
    end
endmodule

/* File: test/sro_i2c_slave_assertions.sv */
// port-level checks for the sensor readout slave
`include "sro_cfg.svh"
module sro_i2c_slave_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // bus pins
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // status
    input wire logic ready_pin,
    input wire logic bus_busy,
    input wire logic rx_strobe,
    input wire logic tx_abort
);
    logic [5:0] held;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            held <= 6'h00;
        end else begin
            held <= scl_oe ? held + 6'h01 : 6'h00;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    sequence s_ack_held;
        ##[0:2] sda_oe [*4];
    endsequence
    sequence s_quiet;
        !sda_oe [*8];
    endsequence
    property p_open_drain; !scl_out && !sda_out; endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");
    property p_stretch_len; $fell(scl_oe) |-> held == `SRO_STRETCH_CYC; endproperty
    a_stretch_len: assert property (p_stretch_len) else $error("stretch length wrong");
    property p_stretch_quiet; scl_oe && $past(scl_oe) |-> $stable(sda_oe) && bus_busy; endproperty
    a_stretch_quiet: assert property (p_stretch_quiet) else $error("stretch outside transfer");
    property p_ready_fall; $rose(bus_busy) |-> ##[0:2] !ready_pin; endproperty
    a_ready_fall: assert property (p_ready_fall) else $error("ready not cleared by start");
    property p_ready_rise; $rose(ready_pin) |-> !$past(bus_busy); endproperty
    a_ready_rise: assert property (p_ready_rise) else $error("ready rose during transfer");
    property p_abort_idle; tx_abort |=> s_quiet; endproperty
    a_abort_idle: assert property (p_abort_idle) else $error("data driven after abort");
    property p_write_ack; rx_strobe |-> s_ack_held; endproperty
    a_write_ack: assert property (p_write_ack) else $error("written byte not acknowledged");
    property p_busy_start; $rose(bus_busy) |-> !sda_in && scl_in; endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy without start");
    property p_busy_end; $fell(bus_busy) |-> sda_in && scl_in; endproperty
    a_busy_end: assert property (p_busy_end) else $error("free without stop");
    property p_data_low_clock; $changed(sda_oe) |-> !scl_in; endproperty
    a_data_low_clock: assert property (p_data_low_clock) else $error("data moved while clock high");
endmodule

bind sro_i2c_slave sro_i2c_slave_assertions u_chk (.clk(clk), .resetn(resetn), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .ready_pin(ready_pin), .bus_busy(bus_busy), .rx_strobe(rx_strobe), .tx_abort(tx_abort));

/* File: test/sro_master_model.sv */
// two-wire bus master model with open-drain pulls
module sro_master_model (
    // clock
    input wire logic clk,
    // bus wires and pulls
    input wire logic scl,
    input wire logic sda,
    output logic scl_low,
    output logic sda_low
);
    timeunit 1ns;
    timeprecision 1ns;
    int held_max = 0;
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one bit cell of eight clocks; waits out a stretched clock
    task automatic bit_x(input logic b, output logic r);
        int i;
        i = 0;
        wt(1);
        sda_low <= !b;
        wt(4);
        scl_low <= 1'b0;
        wt(1);
        while (scl !== 1'b1 && i < 60) begin
            wt(1);
            i++;
        end
        held_max = (i > held_max) ? i : held_max;
        r = sda;
        wt(2);
        scl_low <= 1'b1;
    endtask
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int k = 7; k >= 0; k--) begin
            bit_x(d[k], r);
        end
        bit_x(1'b1, r);
        ack = !r;
    endtask
    task automatic get_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int k = 7; k >= 0; k--) begin
            bit_x(1'b1, r);
            d[k] = r;
        end
        bit_x(!ack, r);
    endtask
    task automatic start_c();
        sda_low <= 1'b1;
        wt(6);
        scl_low <= 1'b1;
    endtask
    task automatic stop_c();
        wt(1);
        sda_low <= 1'b1;
        wt(4);
        scl_low <= 1'b0;
        wt(4);
        sda_low <= 1'b0;
        wt(40);
    endtask
endmodule
